// file: ehu_ctl_model.sv
// Interrupt controller and debug request source facing the event unit
`include "ehu_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module ehu_ctl_model (
    // Clock and core answer
    input  wire logic                 i_clk,
    input  wire logic                 i_irq_ack,
    // Requests toward the core
    output logic                      o_irq_req,
    output logic [`EHU_AV_W-1:0]      o_irq_autovec,
    output logic                      o_dbg_req
);
    initial
    begin
        o_irq_req     = 1'b0;
        o_irq_autovec = '0;
        o_dbg_req     = 1'b0;
    end

    ////////////////////////////////////////////////////////////
    // Level request held until acknowledged; gives up after 8 edges
    task automatic raise_irq(input logic [`EHU_AV_W-1:0] vec, input int dly);
        int n;
        repeat (dly) @(posedge i_clk);
        if (dly > 0)
            #1;
        o_irq_req     = 1'b1;
        o_irq_autovec = vec;
        n = 0;
        do
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        while (i_irq_ack !== 1'b1 && n < 8);
        // Acknowledge read after its launch edge; held until it is sampled
        @(posedge i_clk);
        #1;
        o_irq_req     = 1'b0;
        // Released offset must not look valid
        o_irq_autovec = ~vec;
    endtask

    ////////////////////////////////////////////////////////////
    // Debug request level for a given number of edges
    task automatic raise_dbg(input int len);
        o_dbg_req = 1'b1;
        repeat (len) @(posedge i_clk);
        #1;
        o_dbg_req = 1'b0;
    endtask
endmodule

`default_nettype wire

// file: ehu_event_unit.sv
// Event handling unit: event priority, handler entry, call, return and debug
//
// Overview of operation
// RULE1: Any accepted event halts the instruction stream and redirects to its handler.
// RULE2: Ordinary handlers sit upward from the vector base, four bytes apart.
// RULE3: A few critical handlers get wider spacing for whole routines.
// RULE4: Events have priority classes; a higher class preempts a lower one.
// RULE5: Simultaneous events on one instruction are served in fixed priority order.
// RULE6: Events of the oldest pipeline instruction are served before younger ones.
// RULE7: Interrupt entry is vector base plus the controller's autovector offset.
// RULE8: The autovector offset is 14 bits, below 16384 bytes.
// RULE9: Fetching starts at 0x80000000 after reset.
// RULE10: Translation misses and supervisor call have dedicated handler regions.
// RULE11: Every other exception has its own base-relative entry point.
// RULE12: A protection violation raises a fetch-side or data-side protection exception.
// RULE13: An access hitting no protection entry raises a fetch or data miss.
// RULE14: An access hitting several protection entries raises a multiple-hit exception.
// RULE15: A debug request enters Debug mode unless the debug entry mask is set.
// RULE16: Debug entry sets the debug state flag and branches to the debug handler.
// RULE17: Debug mode runs in exception context, saving into dedicated return registers.
// RULE18: In Debug mode the status mode field is freely writable.
// RULE19: The debug return leaves Debug mode and restores the previous context.
// RULE20: Supervisor call pushes return address and status; supervisor return restores them.
// RULE21: Entry address is vector base plus offset, computed combinationally, never remapped.
`include "ehu_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module ehu_event_unit
    import ehu_pkg::*;
(
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    // Vector base and pipeline state
    input  wire logic [31:0]          i_event_vector_base,
    input  wire logic [31:0]          i_old_pc,
    input  wire logic [31:0]          i_young_pc,
    input  wire logic [`EHU_XN-1:0]   i_old_exc,
    input  wire logic [`EHU_XN-1:0]   i_young_exc,
    // Memory protection unit result
    input  wire logic                 i_mpu_chk,
    input  wire logic                 i_mpu_fetch,
    input  wire logic [1:0]           i_mpu_nhit,
    input  wire logic                 i_mpu_viol,
    // Interrupt controller and debug source
    input  wire logic                 i_irq_req,
    input  wire logic [`EHU_AV_W-1:0] i_irq_autovec,
    input  wire logic                 i_dbg_req,
    // Returns and stack read data
    input  wire logic                 i_rete,
    input  wire logic                 i_rets,
    input  wire logic                 i_retd,
    input  wire logic [31:0]          i_stk_ra,
    input  wire logic [31:0]          i_stk_sr,
    // Status register write
    input  wire logic                 i_sr_we,
    input  wire logic [31:0]          i_sr_wdata,
    // Redirect
    output logic                      o_halt,
    output logic [31:0]               o_target,
    output var ehu_cause_t            o_cause,
    output logic                      o_irq_ack,
    // System stack
    output logic                      o_stk_push,
    output logic                      o_stk_pop,
    output logic [31:0]               o_stk_ra,
    output logic [31:0]               o_stk_sr,
    // Status and debug return registers
    output logic [31:0]               o_sr,
    output logic [31:0]               o_dbg_rar,
    output logic [31:0]               o_dbg_rsr
);

    ////////////////////////////////////////////////////////////////////////////
    logic [31:0]        sr_q;
    logic [31:0]        sr_d;
    logic [2:0]         mode;
    logic               dbg_on;
    logic               mpu_prot;
    logic               mpu_miss;
    logic               mpu_multi;
    logic [`EHU_XN-1:0] mpu_vec;
    logic [`EHU_XN-1:0] old_v;
    logic [`EHU_XN-1:0] young_v;
    logic               irq_ok;
    logic               dbg_ok;
    ehu_cause_t         sel_c;
    logic [31:0]        ofs_c;
    logic [31:0]        ra_c;
    logic [31:0]        entry_c;
    logic               take;
    logic               ret_any;

    assign mode   = sr_q[`EHU_SR_MODE_LO +: 3];
    assign dbg_on = sr_q[`EHU_SR_DSTATE];

    // Protection unit outcome; a miss is only meaningful with zero hits
    assign mpu_miss  = i_mpu_chk && (i_mpu_nhit == 2'h0);                       // RULE13
    assign mpu_multi = i_mpu_chk && (i_mpu_nhit[1] == 1'b1);                    // RULE14
    assign mpu_prot  = i_mpu_chk && (i_mpu_nhit == 2'h1) && i_mpu_viol;         // RULE12

    always_comb
    begin
        mpu_vec = '0;
        mpu_vec[`EHU_X_MULTI] = mpu_multi;                                      // RULE14
        if (i_mpu_fetch)
        begin
            mpu_vec[`EHU_X_IMISS] = mpu_miss;                                   // RULE13
            mpu_vec[`EHU_X_IPROT] = mpu_prot;                                   // RULE12
        end
        else
        begin
            mpu_vec[`EHU_X_DMISS] = mpu_miss;                                   // RULE13
            mpu_vec[`EHU_X_DPROT] = mpu_prot;                                   // RULE12
        end
    end

    // Fetch faults belong to the younger instruction, data faults to the older
    assign old_v   = i_old_exc | (i_mpu_fetch ? '0 : mpu_vec);
    assign young_v = i_young_exc | (i_mpu_fetch ? mpu_vec : '0);

    // Interrupts only preempt a lower class; debug requests ignore the mode, and neither is taken in Debug mode
    assign irq_ok = i_irq_req && !dbg_on && (mode < `EHU_MODE_INT);            // RULE4
    assign dbg_ok = i_dbg_req && !sr_q[`EHU_SR_DMASK] && !dbg_on;              // RULE15

    ////////////////////////////////////////////////////////////////////////////
    function automatic ehu_cause_t pick(input logic [`EHU_XN-1:0] v);
        ehu_cause_t c;
        c = EHU_C_NONE;
        // Lowest index wins: walk downward so the last hit is the highest
        for (int i = `EHU_XN - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                case (i)
                    `EHU_X_MULTI:   c = EHU_C_MULTI;
                    `EHU_X_IMISS:   c = EHU_C_IMISS;
                    `EHU_X_IPROT:   c = EHU_C_IPROT;
                    `EHU_X_ILLEGAL: c = EHU_C_ILLEGAL;
                    `EHU_X_DMISS:   c = EHU_C_DMISS;
                    `EHU_X_DPROT:   c = EHU_C_DPROT;
                    default:        c = EHU_C_SCALL;
                endcase
            end
        end
        return c;
    endfunction

    always_comb
    begin
        sel_c = EHU_C_NONE;
        ra_c  = i_young_pc;
        if (dbg_ok)
            sel_c = EHU_C_DEBUG;
        else if (old_v != '0)
        begin
            sel_c = pick(old_v);                                                // RULE5 RULE6
            ra_c  = i_old_pc;
        end
        else if (irq_ok)
            sel_c = EHU_C_IRQ;
        else if (young_v != '0)
            sel_c = pick(young_v);                                              // RULE6
    end

    always_comb
    begin
        case (sel_c)
            EHU_C_DEBUG:   ofs_c = `EHU_OFS_DEBUG;                              // RULE16
            EHU_C_MULTI:   ofs_c = `EHU_OFS_MULTI;                              // RULE2
            EHU_C_IPROT:   ofs_c = `EHU_OFS_IPROT;                              // RULE11
            EHU_C_ILLEGAL: ofs_c = `EHU_OFS_ILLEGAL;                            // RULE11
            EHU_C_DPROT:   ofs_c = `EHU_OFS_DPROT;                              // RULE11
            EHU_C_IMISS:   ofs_c = `EHU_OFS_IMISS;                              // RULE3 RULE10
            EHU_C_DMISS:   ofs_c = `EHU_OFS_DMISS;                              // RULE3 RULE10
            EHU_C_SCALL:   ofs_c = `EHU_OFS_SCALL;                              // RULE10
            EHU_C_IRQ:     ofs_c = {18'h00000, i_irq_autovec};                  // RULE7 RULE8
            default:       ofs_c = 32'h00000000;
        endcase
    end

    // No remapping: plain sum of base and offset
    assign entry_c = i_event_vector_base + ofs_c;                               // RULE21
    assign take    = (sel_c != EHU_C_NONE);                                     // RULE1
    assign ret_any = !take && (i_rete || i_rets || (i_retd && dbg_on));

    ////////////////////////////////////////////////////////////////////////////
    // Status register: events, returns, then software writes
    always_comb
    begin
        sr_d = sr_q;
        if (take)
        begin
            case (sel_c)
                EHU_C_DEBUG:
                begin
                    sr_d[`EHU_SR_DSTATE] = 1'b1;                                // RULE16
                    sr_d[`EHU_SR_MODE_LO +: 3] = `EHU_MODE_EXC;                 // RULE17
                end
                EHU_C_IRQ:   sr_d[`EHU_SR_MODE_LO +: 3] = `EHU_MODE_INT;
                EHU_C_SCALL: sr_d[`EHU_SR_MODE_LO +: 3] = `EHU_MODE_SUP;
                default:     sr_d[`EHU_SR_MODE_LO +: 3] = `EHU_MODE_EXC;
            endcase
        end
        else if (i_retd && dbg_on)
            sr_d = o_dbg_rsr;                                                   // RULE19
        else if (i_rete || i_rets)
            sr_d = i_stk_sr;                                                    // RULE20
        else if (i_sr_we)
        begin
            sr_d = i_sr_wdata;
            sr_d[`EHU_SR_DSTATE] = dbg_on;
            // Mode change needs privilege, except in Debug mode
            if (!dbg_on && (mode == `EHU_MODE_APP))
                sr_d[`EHU_SR_MODE_LO +: 3] = mode;                              // RULE18
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            sr_q <= `EHU_SR_RESET;
        else
            sr_q <= sr_d;
    end

    // Redirect outputs; reset itself redirects to the boot address
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_halt    <= 1'b1;
            o_target  <= `EHU_RESET_ADDR;                                       // RULE9
            o_cause   <= EHU_C_NONE;
            o_irq_ack <= 1'b0;
        end
        else
        begin
            o_halt    <= take || ret_any;                                       // RULE1
            o_irq_ack <= (sel_c == EHU_C_IRQ);                                  // RULE7
            o_cause   <= sel_c;
            if (take)
                o_target <= entry_c;                                            // RULE21
            else if (i_retd && dbg_on)
                o_target <= o_dbg_rar;                                          // RULE19
            else if (ret_any)
                o_target <= i_stk_ra;                                           // RULE20
        end
    end

    // Stack traffic; debug entry avoids the stack entirely
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_stk_push <= 1'b0;
            o_stk_pop  <= 1'b0;
            o_stk_ra   <= 32'h00000000;
            o_stk_sr   <= 32'h00000000;
        end
        else
        begin
            o_stk_push <= take && (sel_c != EHU_C_DEBUG);                       // RULE17 RULE20
            o_stk_pop  <= !take && (i_rete || i_rets) && !(i_retd && dbg_on);   // RULE20
            if (take && (sel_c != EHU_C_DEBUG))
            begin
                o_stk_ra <= ra_c;                                               // RULE20
                o_stk_sr <= sr_q;
            end
        end
    end

    // Dedicated debug return registers
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_dbg_rar <= 32'h00000000;
            o_dbg_rsr <= 32'h00000000;
        end
        else if (sel_c == EHU_C_DEBUG)
        begin
            o_dbg_rar <= ra_c;                                                  // RULE17
            o_dbg_rsr <= sr_q;
        end
    end

    assign o_sr = sr_q;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    chk_entry_addr: assert property (take |=> o_halt && o_target == $past(entry_c)) // RULE1
        else $error("entry redirect wrong");
    chk_irq_vector: assert property ((sel_c == EHU_C_IRQ) |=>                   // RULE7
        o_target == $past(i_event_vector_base) + {18'h00000, $past(i_irq_autovec)})
        else $error("irq entry address wrong");
    chk_irq_span: assert property (o_irq_ack |->                                // RULE8
        (o_target - $past(i_event_vector_base)) < 32'h00004000)
        else $error("autovector beyond range");
    chk_old_first: assert property ((old_v != '0 && !dbg_ok) |=>                // RULE6
        o_stk_ra == $past(i_old_pc))
        else $error("younger event served first");
    chk_multi_prio: assert property ((old_v[`EHU_X_MULTI] && !dbg_ok) |=>      // RULE5
        o_cause == EHU_C_MULTI)
        else $error("priority order wrong");
    chk_dbg_mask: assert property ((i_dbg_req && sr_q[`EHU_SR_DMASK]) |=>      // RULE15
        o_cause != EHU_C_DEBUG)
        else $error("masked debug entry taken");
    chk_dbg_entry: assert property (dbg_ok |=> o_sr[`EHU_SR_DSTATE] && !o_stk_push // RULE16
        && o_target == $past(i_event_vector_base) + `EHU_OFS_DEBUG)
        else $error("debug entry wrong");
    chk_dbg_exit: assert property ((i_retd && dbg_on && !take) |=>              // RULE19
        o_sr == $past(o_dbg_rsr) && o_target == $past(o_dbg_rar))
        else $error("debug return wrong");
    chk_scall_push: assert property ((sel_c == EHU_C_SCALL) |=>                 // RULE20
        o_stk_push && o_stk_sr == $past(sr_q))
        else $error("scall did not save context");
    chk_mpu_prot: assert property ((mpu_prot && i_mpu_fetch && !dbg_ok && !irq_ok // RULE12
        && old_v == '0 && i_young_exc[1:0] == 2'h0) |=> o_cause == EHU_C_IPROT)
        else $error("fetch protection lost");
    chk_irq_hold: assert property ((i_irq_req && mode == `EHU_MODE_INT) |=>     // RULE4
        !o_irq_ack)
        else $error("irq preempted same class");

    cov_irq: cover property (sel_c == EHU_C_IRQ ##1 o_irq_ack);
    cov_dbg: cover property (sel_c == EHU_C_DEBUG ##[1:20] i_retd);
    cov_scall_ret: cover property (sel_c == EHU_C_SCALL ##[1:20] i_rets);
    cov_both_stages: cover property (old_v != '0 && young_v != '0);

endmodule

`default_nettype wire

// file: ehu_event_unit_tb.sv
// Self-checking testbench of the event handling unit
`include "ehu_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module ehu_event_unit_tb;
    import ehu_pkg::*;

    localparam logic [31:0] BASE = 32'h80002000;
    localparam logic [31:0] OPC  = 32'h80000100;
    localparam logic [31:0] YPC  = 32'h80000104;

    logic                 i_clk;
    logic                 i_rst_n;
    logic [`EHU_XN-1:0]   i_old_exc;
    logic [`EHU_XN-1:0]   i_young_exc;
    logic                 i_mpu_chk;
    logic                 i_mpu_fetch;
    logic [1:0]           i_mpu_nhit;
    logic                 i_mpu_viol;
    logic                 i_irq_req;
    logic [`EHU_AV_W-1:0] i_irq_autovec;
    logic                 i_dbg_req;
    logic                 i_rete;
    logic                 i_rets;
    logic                 i_retd;
    logic [31:0]          i_stk_ra;
    logic [31:0]          i_stk_sr;
    logic                 i_sr_we;
    logic [31:0]          i_sr_wdata;
    logic                 o_halt;
    logic [31:0]          o_target;
    ehu_cause_t           o_cause;
    logic                 o_irq_ack;
    logic                 o_stk_push;
    logic                 o_stk_pop;
    logic [31:0]          o_stk_ra;
    logic [31:0]          o_stk_sr;
    logic [31:0]          o_sr;
    logic [31:0]          o_dbg_rar;
    logic [31:0]          o_dbg_rsr;
    int                   n_errors;
    int                   n_compared;

    ehu_event_unit i_ehu_event_unit (
        .i_clk, .i_rst_n, .i_event_vector_base(BASE), .i_old_pc(OPC), .i_young_pc(YPC),
        .i_old_exc, .i_young_exc, .i_mpu_chk, .i_mpu_fetch, .i_mpu_nhit, .i_mpu_viol,
        .i_irq_req, .i_irq_autovec, .i_dbg_req, .i_rete, .i_rets, .i_retd, .i_stk_ra,
        .i_stk_sr, .i_sr_we, .i_sr_wdata, .o_halt, .o_target, .o_cause, .o_irq_ack,
        .o_stk_push, .o_stk_pop, .o_stk_ra, .o_stk_sr, .o_sr, .o_dbg_rar, .o_dbg_rsr
    );

    ehu_ctl_model i_ehu_ctl_model (
        .i_clk, .i_irq_ack(o_irq_ack), .o_irq_req(i_irq_req),
        .o_irq_autovec(i_irq_autovec), .o_dbg_req(i_dbg_req)
    );

    ////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic step();
        @(posedge i_clk);
        #1;
    endtask

    task automatic quiet();
        i_old_exc   = '0;
        i_young_exc = '0;
        i_mpu_chk   = 1'b0;
        i_rete      = 1'b0;
        i_rets      = 1'b0;
        i_retd      = 1'b0;
        i_sr_we     = 1'b0;
    endtask

    // Bounded wait; a missing redirect ends the run
    task automatic wait_halt(input logic want);
        logic seen;
        seen = 1'b0;
        for (int k = 0; k < 12 && seen !== 1'b1; k++)
        begin
            step();
            seen = o_halt;
        end
        check("halt", {31'h0, seen}, {31'h0, want});
        if (want && seen !== 1'b1)
            tally_and_finish();
    endtask

    task automatic do_reset();
        i_rst_n = 1'b0;
        quiet();
        repeat (2) step();
        check("reset target", o_target, `EHU_RESET_ADDR);
        check("reset halt", {31'h0, o_halt}, 32'h1);
        check("reset status", o_sr, `EHU_SR_RESET);
        i_rst_n = 1'b1;
        step();
        check("halt after reset", {31'h0, o_halt}, 32'h0);
    endtask

    task automatic entry(input string what, input logic [31:0] tgt, input ehu_cause_t c);
        check(what, o_target, tgt);
        check(what, {31'h0, o_halt}, 32'h1);
        check(what, {28'h0, o_cause}, {28'h0, c});
    endtask

    ////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_exc_table();
        logic [31:0] ofs [7] = '{`EHU_OFS_MULTI, `EHU_OFS_IMISS, `EHU_OFS_IPROT,
            `EHU_OFS_ILLEGAL, `EHU_OFS_DMISS, `EHU_OFS_DPROT, `EHU_OFS_SCALL};
        ehu_cause_t  cs [7] = '{EHU_C_MULTI, EHU_C_IMISS, EHU_C_IPROT, EHU_C_ILLEGAL,
            EHU_C_DMISS, EHU_C_DPROT, EHU_C_SCALL};
        for (int i = 0; i < 7; i++)
        begin
            do_reset();
            i_old_exc[i] = 1'b1;
            step();
            quiet();
            entry("exception entry", BASE + ofs[i], cs[i]);
        end
        do_reset();
        i_old_exc   = 7'h7f;
        i_young_exc = 7'h7f;
        step();
        quiet();
        entry("same instruction", BASE + `EHU_OFS_MULTI, EHU_C_MULTI);
        do_reset();
        i_old_exc[`EHU_X_ILLEGAL] = 1'b1;
        i_young_exc[`EHU_X_MULTI] = 1'b1;
        step();
        quiet();
        entry("oldest first", BASE + `EHU_OFS_ILLEGAL, EHU_C_ILLEGAL);
        $display("exception table done");
    endtask

    task automatic t_mpu();
        // Packed as fetch, hit count, violation
        logic [3:0]  acc [6] = '{4'h8, 4'h0, 4'hb, 4'h3, 4'hc, 4'h6};
        ehu_cause_t  cs [6]  = '{EHU_C_IMISS, EHU_C_DMISS, EHU_C_IPROT, EHU_C_DPROT,
            EHU_C_MULTI, EHU_C_MULTI};
        logic [31:0] ofs [6] = '{`EHU_OFS_IMISS, `EHU_OFS_DMISS, `EHU_OFS_IPROT,
            `EHU_OFS_DPROT, `EHU_OFS_MULTI, `EHU_OFS_MULTI};
        for (int i = 0; i < 7; i++)
        begin
            do_reset();
            i_mpu_chk = 1'b1;
            {i_mpu_fetch, i_mpu_nhit, i_mpu_viol} = (i < 6) ? acc[i] : 4'h2;
            step();
            quiet();
            if (i < 6)
                entry("protection fault", BASE + ofs[i], cs[i]);
            else
                check("clean access", {31'h0, o_halt}, 32'h0);
        end
        $display("protection faults done");
    endtask

    task automatic t_irq();
        do_reset();
        fork
            i_ehu_ctl_model.raise_irq(14'h3ffc, 2);
            begin
                wait_halt(1'b1);
                entry("irq entry", BASE + 32'h3ffc, EHU_C_IRQ);
                check("irq ack", {31'h0, o_irq_ack}, 32'h1);
                check("irq mode", {29'h0, o_sr[24:22]}, {29'h0, `EHU_MODE_INT});
            end
        join
        step();
        fork
            i_ehu_ctl_model.raise_irq(14'h0100, 0);
            wait_halt(1'b0);
        join
        i_rete   = 1'b1;
        i_stk_ra = YPC;
        i_stk_sr = `EHU_SR_RESET;
        step();
        quiet();
        check("rete pop", {31'h0, o_stk_pop}, 32'h1);
        check("rete target", o_target, YPC);
        check("rete status", o_sr, `EHU_SR_RESET);
        $display("interrupt done");
    endtask

    task automatic t_debug();
        do_reset();
        fork
            i_ehu_ctl_model.raise_irq(14'h0040, 0);
            i_ehu_ctl_model.raise_dbg(2);
            begin
                wait_halt(1'b1);
                entry("debug entry", BASE + `EHU_OFS_DEBUG, EHU_C_DEBUG);
                check("debug flag", {31'h0, o_sr[`EHU_SR_DSTATE]}, 32'h1);
                check("debug rar", o_dbg_rar, YPC);
                check("debug rsr", o_dbg_rsr, `EHU_SR_RESET);
                check("debug push", {31'h0, o_stk_push}, 32'h0);
                check("debug mode", {29'h0, o_sr[24:22]}, {29'h0, `EHU_MODE_EXC});
            end
        join
        i_sr_we    = 1'b1;
        i_sr_wdata = 32'h0;
        step();
        quiet();
        check("debug mode write", {29'h0, o_sr[24:22]}, 32'h0);
        check("debug flag kept", {31'h0, o_sr[`EHU_SR_DSTATE]}, 32'h1);
        i_retd = 1'b1;
        step();
        quiet();
        check("retd target", o_target, YPC);
        check("retd status", o_sr, `EHU_SR_RESET);
        i_sr_we    = 1'b1;
        i_sr_wdata = 32'h04400000;
        step();
        quiet();
        check("mask write", o_sr, 32'h04400000);
        fork
            i_ehu_ctl_model.raise_dbg(2);
            wait_halt(1'b0);
        join
        i_retd = 1'b1;
        step();
        quiet();
        check("retd outside debug", {31'h0, o_halt}, 32'h0);
        $display("debug done");
    endtask

    task automatic t_scall();
        do_reset();
        i_old_exc[`EHU_X_SCALL] = 1'b1;
        step();
        quiet();
        entry("scall entry", BASE + `EHU_OFS_SCALL, EHU_C_SCALL);
        check("scall push", {31'h0, o_stk_push}, 32'h1);
        check("scall ra", o_stk_ra, OPC);
        check("scall sr", o_stk_sr, `EHU_SR_RESET);
        i_rets   = 1'b1;
        i_stk_ra = 32'h80001234;
        i_stk_sr = 32'h0;
        step();
        quiet();
        check("rets pop", {31'h0, o_stk_pop}, 32'h1);
        check("rets target", o_target, 32'h80001234);
        check("rets status", o_sr, 32'h0);
        $display("supervisor call done");
    endtask

    ////////////////////////////////////////////////////////////
    // Clock, watchdog and main sequence
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    initial
    begin
        #500000;
        n_errors++;
        tally_and_finish();
    end

    initial
    begin
        n_errors    = 0;
        n_compared  = 0;
        i_rst_n     = 1'b0;
        i_mpu_fetch = 1'b0;
        i_mpu_nhit  = 2'h1;
        i_mpu_viol  = 1'b0;
        i_stk_ra    = 32'h0;
        i_stk_sr    = 32'h0;
        i_sr_wdata  = 32'h0;
        quiet();
        t_exc_table();
        t_mpu();
        t_irq();
        t_debug();
        t_scall();
        tally_and_finish();
    end
endmodule

`default_nettype wire

// file: ehu_pkg.sv
// Types of the event handling unit
package ehu_pkg;

    typedef enum logic [3:0] {
        EHU_C_NONE,
        EHU_C_DEBUG,
        EHU_C_MULTI,
        EHU_C_IMISS,
        EHU_C_IPROT,
        EHU_C_ILLEGAL,
        EHU_C_DMISS,
        EHU_C_DPROT,
        EHU_C_IRQ,
        EHU_C_SCALL
    } ehu_cause_t;

endpackage

// file: ehu_regs.svh
// Constants of the event handling unit: addresses, offsets, status fields
`ifndef EHU_REGS_SVH
`define EHU_REGS_SVH

`define EHU_RESET_ADDR   32'h80000000
`define EHU_AV_W         14
// Exception vector bit positions, highest priority at bit 0
`define EHU_X_MULTI      0
`define EHU_X_IMISS      1
`define EHU_X_IPROT      2
`define EHU_X_ILLEGAL    3
`define EHU_X_DMISS      4
`define EHU_X_DPROT      5
`define EHU_X_SCALL      6
`define EHU_XN           7
// Handler offsets from the vector base
`define EHU_OFS_DEBUG    32'h00000000
`define EHU_OFS_MULTI    32'h00000004
`define EHU_OFS_IPROT    32'h00000008
`define EHU_OFS_ILLEGAL  32'h0000000c
`define EHU_OFS_DPROT    32'h00000010
`define EHU_OFS_IMISS    32'h00000050
`define EHU_OFS_DMISS    32'h00000060
`define EHU_OFS_SCALL    32'h00000100
// Status register fields
`define EHU_SR_DMASK     26
`define EHU_SR_DSTATE    27
`define EHU_SR_MODE_LO   22
`define EHU_SR_RESET     32'h00400000
`define EHU_MODE_APP     3'h0
`define EHU_MODE_SUP     3'h1
`define EHU_MODE_INT     3'h2
`define EHU_MODE_EXC     3'h3

`endif
